// ==== hdl/bsr_pkg.sv ====
`default_nettype none
//==============================================================
// Shared constants for both ends of the barometer link.
//==============================================================
package bsr_pkg;

	// Timing base and conversion time.
	localparam int PCLK_MHZ      = 200;
	localparam int CONV_TIME_MS  = 5;
	localparam int CONV_CYC      = CONV_TIME_MS * 1000 * PCLK_MHZ;
	localparam int I2C_FREQ_KHZ  = 400;
	// Quarter of the fastest serial clock period, rounded up so the rate never exceeds it.
	localparam int SCL_QTR_CYC   = (PCLK_MHZ * 1000 + I2C_FREQ_KHZ * 4 - 1) / (I2C_FREQ_KHZ * 4);

	// Device addressing and command codes.
	localparam logic [6:0] DEV_ADDR     = 7'h6C;
	localparam logic [7:0] I2C_WR_ADDR  = {DEV_ADDR, 1'b0};
	localparam logic [7:0] I2C_RD_ADDR  = {DEV_ADDR, 1'b1};
	localparam logic [7:0] REG_PRES_HI  = 8'h06;
	localparam logic [7:0] REG_PRES_MID = 8'h07;
	localparam logic [7:0] REG_PRES_LO  = 8'h08;
	localparam logic [7:0] REG_TEMP_HI  = 8'h09;
	localparam logic [7:0] REG_TEMP_LO  = 8'h0A;
	localparam logic [7:0] REG_TRIG     = 8'h30;
	localparam logic [7:0] MR_CODE      = 8'h0A;
	localparam logic [7:0] SPI_RD_CMD   = 8'h80;
	localparam logic [7:0] SPI_WR_CMD   = 8'h00;

	// Index of the last byte of each host sequence.
	localparam logic [3:0] MEAS_LAST      = 4'h2;
	localparam logic [3:0] I2C_FULL_LAST  = 4'h7;
	localparam logic [3:0] I2C_PONLY_LAST = 4'h5;
	localparam logic [3:0] SPI_FULL_LAST  = 4'hE;
	localparam logic [3:0] SPI_PONLY_LAST = 4'h8;

	// Host controller register map and fields.
	localparam logic [11:0] HREG_CTRL = 12'h000;
	localparam logic [11:0] HREG_STAT = 12'h004;
	localparam logic [11:0] HREG_PRES = 12'h008;
	localparam logic [11:0] HREG_TEMP = 12'h00C;
	localparam int CTRL_MEAS  = 0;
	localparam int CTRL_FETCH = 1;
	localparam int CTRL_SPI   = 2;
	localparam int CTRL_PONLY = 3;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_NACK  = 1;
	localparam int STAT_WAIT  = 2;

endpackage : bsr_pkg
`default_nettype wire

// ==== hdl/bsr_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Serial link between host controller and sensor device.
//==============================================================
interface bsr_link_if;
	logic scl;      // Serial clock, host driven.
	logic sel;      // Mode select, low picks SPI.
	logic h_sda_o;  // Host data out.
	logic h_sda_oe; // Host data enable.
	logic d_sda_o;  // Device data out.
	logic d_sda_oe; // Device data enable.
	logic sda;      // Resolved data line.

	// An undriven line floats high through the pull-up.
	assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

	modport host (output scl, output sel, output h_sda_o, output h_sda_oe, input sda);
	modport dev (input scl, input sel, input sda, output d_sda_o, output d_sda_oe);
endinterface : bsr_link_if
`default_nettype wire

// ==== hdl/bsr_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sleep until measure request, measure, sleep again.
// - Select low gives SPI, high gives I2C.
// - I2C answers only fixed address 0x6C.
// - Fetch never converts; returns stored results.
// - Snapshot packet at transfer start only.
// - Pressure 24 bits, big-endian, MSB first.
// - I2C read: address ACKed, master ends it.
// - I2C fetch writes 0x06, restarts, reads five.
// - Temperature is 16-bit two's complement.
// - Master may stop after pressure bytes.
// - Pressure then temperature, compensated, then stored.
// - I2C measure: address, 0x30, 0x0A, stop.
// - Master waits 5 ms between requests.
// - SPI samples rising, drives falling clock.
// - SPI fetch: 0x80, address, data byte triplets.
// - SPI master may stop after ninth byte.
// - Sensor powered only during conversion.
// - SPI uses one shared half-duplex data line.
// - SPI measure: 0x00, 0x30, 0x0A bytes.
module bsr_device
	import bsr_pkg::*;
#(
	parameter int unsigned PHASE_CYC = CONV_CYC / 2,
	parameter logic [23:0] P_OFS     = 24'h000000,
	parameter logic [15:0] T_OFS     = 16'h0000
) (
	input  wire logic        pclk,       // System clock.
	input  wire logic        presetn,    // Asynchronous reset, low active.
	input  wire logic        clk_en,     // Freezes all state while low.
	bsr_link_if.dev          lnk,        // Serial link to the host.
	input  wire logic [23:0] press_raw,  // Raw pressure from the converter.
	input  wire logic [15:0] temp_raw,   // Raw temperature from the converter.
	output logic             sensor_pwr, // Sensing element supply switch.
	output logic             asleep,     // High while sleeping.
	output logic             spi_mode    // High while link is in SPI mode.
);

	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_AACK, D_RX, D_RACK, D_TX, D_TACK, D_SPI}
		bsr_dev_state_type;
	typedef enum logic [1:0] {M_SLEEP, M_PRES, M_TEMP} bsr_meas_state_type;

	logic [2:0]         scl_q;
	logic [2:0]         sda_q;
	logic [2:0]         sel_q;
	bsr_dev_state_type  st_q;
	bsr_meas_state_type ms_q;
	logic [3:0]         bit_q;
	logic [1:0]         pos_q;
	logic [7:0]         sh_q;
	logic [7:0]         cmd_q;
	logic [7:0]         ptr_q;
	logic [7:0]         txb_q;
	logic [39:0]        pkt_q;
	logic [39:0]        res_q;
	logic [23:0]        p_cmp_q;
	logic [31:0]        cnt_q;
	logic               rw_q;
	logic               o_q;
	logic               oe_q;
	logic               mr_q;
	logic               pwr_q;
	logic               asleep_q;
	logic               spi_q;

	//==============================================================
	// Pin synchronisers and edge detection
	//==============================================================
	// Bit 0 is the first stage, bit 1 the synced level, bit 2 the previous level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			sel_q <= 3'h7;
		end else if (clk_en) begin
			scl_q <= {scl_q[1:0], lnk.scl};
			sda_q <= {sda_q[1:0], lnk.sda};
			sel_q <= {sel_q[1:0], lnk.sel};
		end
	end

	logic       scl_r;
	logic       scl_f;
	logic       sda_s;
	logic       sel_f;
	logic       sel_r;
	logic       i2c_sta;
	logic       i2c_sto;
	logic [7:0] rx_byte;

	// Start and stop are only looked for while select is high.
	assign scl_r   = scl_q[1] & ~scl_q[2];
	assign scl_f   = ~scl_q[1] & scl_q[2];
	assign sda_s   = sda_q[1];
	assign sel_f   = ~sel_q[1] & sel_q[2];
	assign sel_r   = sel_q[1] & ~sel_q[2];
	assign i2c_sta = sel_q[1] & scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign i2c_sto = sel_q[1] & scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
	assign rx_byte = {sh_q[6:0], sda_s};

	// Picks one result byte by register address; unknown addresses read zero.
	function automatic logic [7:0] pick_byte(input logic [39:0] pkt, input logic [7:0] a);
		case (a)
			REG_PRES_HI:  pick_byte = pkt[39:32];
			REG_PRES_MID: pick_byte = pkt[31:24];
			REG_PRES_LO:  pick_byte = pkt[23:16];
			REG_TEMP_HI:  pick_byte = pkt[15:8];
			REG_TEMP_LO:  pick_byte = pkt[7:0];
			default:      pick_byte = 8'h00;
		endcase
	endfunction : pick_byte

	//==============================================================
	// Link protocol engine
	//==============================================================
	// Select edges outrank bus conditions so a mode change always aborts cleanly.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q  <= D_IDLE;
			bit_q <= 4'h0;
			pos_q <= 2'h0;
			sh_q  <= 8'h00;
			cmd_q <= 8'h00;
			ptr_q <= 8'h00;
			txb_q <= 8'h00;
			pkt_q <= 40'h0;
			rw_q  <= 1'b0;
			o_q   <= 1'b0;
			oe_q  <= 1'b0;
			mr_q  <= 1'b0;
		end else if (clk_en) begin
			mr_q <= 1'b0;
			if (sel_f) begin
				st_q  <= D_SPI;
				pkt_q <= res_q;
				bit_q <= 4'h0;
				pos_q <= 2'h0;
				oe_q  <= 1'b0;
			end else if (sel_r) begin
				st_q <= D_IDLE;
				oe_q <= 1'b0;
			end else if (i2c_sta) begin
				st_q  <= D_ADDR;
				bit_q <= 4'h0;
				pos_q <= 2'h0;
				oe_q  <= 1'b0;
			end else if (i2c_sto) begin
				st_q <= D_IDLE;
				oe_q <= 1'b0;
			end else if (scl_r) begin
				case (st_q)
					D_ADDR, D_RX: begin
						sh_q  <= rx_byte;
						bit_q <= bit_q + 4'h1;
					end
					D_TX: bit_q <= bit_q + 4'h1;
					D_TACK: if (sda_s) st_q <= D_IDLE;
					D_SPI: begin
						sh_q <= rx_byte;
						if (bit_q == 4'h7) begin
							bit_q <= 4'h0;
							pos_q <= (pos_q == 2'h2) ? 2'h0 : pos_q + 2'h1;
							case (pos_q)
								2'h0: cmd_q <= rx_byte;
								2'h1: begin
									ptr_q <= rx_byte;
									txb_q <= pick_byte(pkt_q, rx_byte);
								end
								default: begin
									if (cmd_q == SPI_WR_CMD && ptr_q == REG_TRIG && rx_byte == MR_CODE)
										mr_q <= 1'b1;
								end
							endcase
						end else begin
							bit_q <= bit_q + 4'h1;
						end
					end
					default: ;
				endcase
			end else if (scl_f) begin
				case (st_q)
					D_ADDR: begin
						if (bit_q == 4'h8) begin
							bit_q <= 4'h0;
							if (sh_q[7:1] == DEV_ADDR) begin
								st_q <= D_AACK;
								rw_q <= sh_q[0];
								o_q  <= 1'b0;
								oe_q <= 1'b1;
								if (sh_q[0])
									pkt_q <= res_q;
							end else begin
								st_q <= D_IDLE;
							end
						end
					end
					D_AACK, D_TACK: begin
						bit_q <= 4'h0;
						if (rw_q) begin
							// Open drain: a one is sent by letting go of the line.
							st_q  <= D_TX;
							o_q   <= 1'b0;
							oe_q  <= ~pkt_q[39];
							pkt_q <= {pkt_q[38:0], 1'b0};
						end else begin
							st_q <= D_RX;
							oe_q <= 1'b0;
						end
					end
					D_TX: begin
						if (bit_q == 4'h8) begin
							st_q <= D_TACK;
							oe_q <= 1'b0;
						end else begin
							oe_q  <= ~pkt_q[39];
							pkt_q <= {pkt_q[38:0], 1'b0};
						end
					end
					D_RX: begin
						if (bit_q == 4'h8) begin
							st_q <= D_RACK;
							o_q  <= 1'b0;
							oe_q <= 1'b1;
							if (pos_q == 2'h0) begin
								ptr_q <= sh_q;
								pos_q <= 2'h1;
							end else if (ptr_q == REG_TRIG && sh_q == MR_CODE) begin
								mr_q <= 1'b1;
							end
						end
					end
					D_RACK: begin
						st_q  <= D_RX;
						bit_q <= 4'h0;
						oe_q  <= 1'b0;
					end
					D_SPI: begin
						// Third byte of a read triplet goes out on the shared line.
						if (pos_q == 2'h2 && cmd_q == SPI_RD_CMD) begin
							o_q  <= txb_q[3'(3'h7 - bit_q[2:0])];
							oe_q <= 1'b1;
						end else begin
							oe_q <= 1'b0;
						end
					end
					default: ;
				endcase
			end
		end
	end

	//==============================================================
	// Measurement sequencer
	//==============================================================
	// Requests during a running cycle are dropped; the host spaces them out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_q     <= M_SLEEP;
			cnt_q    <= 32'h0;
			p_cmp_q  <= 24'h0;
			res_q    <= 40'h0;
			pwr_q    <= 1'b0;
			asleep_q <= 1'b1;
		end else if (clk_en) begin
			case (ms_q)
				M_SLEEP: begin
					if (mr_q) begin
						ms_q     <= M_PRES;
						cnt_q    <= 32'h0;
						pwr_q    <= 1'b1;
						asleep_q <= 1'b0;
					end
				end
				M_PRES: begin
					if (cnt_q == 32'(PHASE_CYC - 1)) begin
						p_cmp_q <= press_raw + P_OFS;
						cnt_q   <= 32'h0;
						ms_q    <= M_TEMP;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				M_TEMP: begin
					if (cnt_q == 32'(PHASE_CYC - 1)) begin
						// Offset wraps mod 2^16, so the sign coding survives.
						res_q    <= {p_cmp_q, temp_raw + T_OFS};
						pwr_q    <= 1'b0;
						asleep_q <= 1'b1;
						ms_q     <= M_SLEEP;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				default: ms_q <= M_SLEEP;
			endcase
		end
	end

	// Mode flag follows the synced select level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			spi_q <= 1'b0;
		else if (clk_en)
			spi_q <= ~sel_q[1];
	end

	assign lnk.d_sda_o  = o_q;
	assign lnk.d_sda_oe = oe_q;
	assign sensor_pwr   = pwr_q;
	assign asleep       = asleep_q;
	assign spi_mode     = spi_q;

endmodule : bsr_device
`default_nettype wire

// ==== hdl/bsr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsr_host
	import bsr_pkg::*;
#(
	parameter int unsigned QTR_CYC   = SCL_QTR_CYC,
	parameter int unsigned GUARD_CYC = CONV_CYC
) (
	input  wire logic        pclk,    // System clock.
	input  wire logic        presetn, // Asynchronous reset, low active.
	input  wire logic        clk_en,  // Freezes all state while low.
	input  wire logic [11:0] paddr,   // APB address.
	input  wire logic        psel,    // APB select.
	input  wire logic        penable, // APB enable.
	input  wire logic        pwrite,  // APB direction.
	input  wire logic [31:0] pwdata,  // APB write data.
	output logic      [31:0] prdata,  // APB read data.
	output logic             pready,  // APB ready.
	output logic             pslverr, // APB error on unmapped address.
	bsr_link_if.host         lnk      // Serial link to the device.
);

	typedef enum logic [1:0] {H_IDLE, H_STA, H_BIT, H_STO} bsr_host_state_type;

	bsr_host_state_type st_q;
	logic [1:0]  sda_q;
	logic [15:0] qcnt_q;
	logic [1:0]  ph_q;
	logic [3:0]  bi_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic [39:0] rd_q;
	logic [23:0] pres_q;
	logic [15:0] temp_q;
	logic [23:0] guard_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        spi_q;
	logic        ponly_q;
	logic        meas_q;
	logic        pmeas_q;
	logic        pfetch_q;
	logic        nack_q;
	logic        scl_q;
	logic        sel_q;
	logic        o_q;
	logic        oe_q;

	// Byte descriptor: {last, read, restart, value} for one step of a sequence.
	function automatic logic [11:0] hdesc(input logic spi, input logic meas,
			input logic ponly, input logic [3:0] bi);
		logic [3:0] lst;
		logic       rd;
		logic       rs;
		logic [7:0] v;
		rd = 1'b0;
		rs = 1'b0;
		v  = 8'h00;
		if (meas) begin
			lst = MEAS_LAST;
			case (bi)
				4'h0:    v = spi ? SPI_WR_CMD : I2C_WR_ADDR;
				4'h1:    v = REG_TRIG;
				default: v = MR_CODE;
			endcase
		end else if (spi) begin
			lst = ponly ? SPI_PONLY_LAST : SPI_FULL_LAST;
			case (bi % 4'h3)
				4'h0:    v = SPI_RD_CMD;
				4'h1:    v = REG_PRES_HI + {4'h0, bi / 4'h3};
				default: rd = 1'b1;
			endcase
		end else begin
			lst = ponly ? I2C_PONLY_LAST : I2C_FULL_LAST;
			case (bi)
				4'h0:    v = I2C_WR_ADDR;
				4'h1:    v = REG_PRES_HI;
				4'h2: begin
					v  = I2C_RD_ADDR;
					rs = 1'b1;
				end
				default: rd = 1'b1;
			endcase
		end
		return {bi == lst, rd, rs, 1'b0, v};
	endfunction : hdesc

	logic [11:0] d_cur;
	logic [11:0] d_nxt;
	logic [11:0] d_go;
	logic        busy;
	logic        launch;
	logic        tick;
	logic        sda_s;
	logic        nack_now;
	logic        acc;

	assign d_cur    = hdesc(spi_q, meas_q, ponly_q, bi_q);
	assign d_nxt    = hdesc(spi_q, meas_q, ponly_q, bi_q + 4'h1);
	assign d_go     = hdesc(spi_q, pmeas_q, ponly_q, 4'h0);
	assign busy     = pmeas_q | pfetch_q | (st_q != H_IDLE);
	assign launch   = (st_q == H_IDLE) && (guard_q == 24'h0) && (pmeas_q | pfetch_q);
	assign tick     = (st_q != H_IDLE) && (qcnt_q == 16'(QTR_CYC - 1));
	assign sda_s    = sda_q[1];
	assign nack_now = (bit_q == 4'h8) && !d_cur[10] && sda_s;
	assign acc      = psel & penable;

	//==============================================================
	// APB slave
	//==============================================================
	// One wait state keeps read data and ready straight from flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
			spi_q     <= 1'b0;
			ponly_q   <= 1'b0;
			pmeas_q   <= 1'b0;
			pfetch_q  <= 1'b0;
		end else if (clk_en) begin
			pready_q  <= acc & ~pready_q;
			pslverr_q <= 1'b0;
			if (acc && !pready_q) begin
				case (paddr)
					HREG_CTRL: prdata_q <= {28'h0, ponly_q, spi_q, pfetch_q, pmeas_q};
					HREG_STAT: prdata_q <= {29'h0, guard_q != 24'h0, nack_q, busy};
					HREG_PRES: prdata_q <= {8'h00, pres_q};
					HREG_TEMP: prdata_q <= {16'h0000, temp_q};
					default: begin
						prdata_q  <= 32'h0;
						pslverr_q <= 1'b1;
					end
				endcase
			end
			if (launch) begin
				if (pmeas_q)
					pmeas_q <= 1'b0;
				else
					pfetch_q <= 1'b0;
			end
			// Control writes are dropped while a sequence is pending or running.
			if (acc && pready_q && pwrite && paddr == HREG_CTRL && !busy) begin
				spi_q    <= pwdata[CTRL_SPI];
				ponly_q  <= pwdata[CTRL_PONLY];
				pmeas_q  <= pwdata[CTRL_MEAS];
				pfetch_q <= pwdata[CTRL_FETCH];
			end
		end
	end

	//==============================================================
	// Serial clock divider and data synchroniser
	//==============================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qcnt_q <= 16'h0;
			ph_q   <= 2'h0;
			sda_q  <= 2'h3;
		end else if (clk_en) begin
			sda_q <= {sda_q[0], lnk.sda};
			if (st_q == H_IDLE || tick) begin
				qcnt_q <= 16'h0;
				ph_q   <= (st_q == H_IDLE) ? 2'h0 : ph_q + 2'h1;
			end else begin
				qcnt_q <= qcnt_q + 16'h1;
			end
		end
	end

	//==============================================================
	// Link sequencer
	//==============================================================
	// Data bits: phase 0 drops the clock and sets data, phase 2 raises it, phase 3 samples; start and I2C stop raise it in phase 1.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q    <= H_IDLE;
			bi_q    <= 4'h0;
			bit_q   <= 4'h0;
			sh_q    <= 8'h00;
			rd_q    <= 40'h0;
			pres_q  <= 24'h0;
			temp_q  <= 16'h0;
			guard_q <= 24'h0;
			meas_q  <= 1'b0;
			nack_q  <= 1'b0;
			scl_q   <= 1'b1;
			sel_q   <= 1'b1;
			o_q     <= 1'b0;
			oe_q    <= 1'b0;
		end else if (clk_en) begin
			if (guard_q != 24'h0)
				guard_q <= guard_q - 24'h1;
			if (launch) begin
				meas_q <= pmeas_q;
				nack_q <= 1'b0;
				bi_q   <= 4'h0;
				bit_q  <= 4'h0;
				sh_q   <= d_go[7:0];
				st_q   <= spi_q ? H_BIT : H_STA;
				if (spi_q)
					sel_q <= 1'b0;
			end else if (tick) begin
				case (st_q)
					H_STA: begin
						case (ph_q)
							2'h0: begin
								scl_q <= 1'b0;
								oe_q  <= 1'b0;
							end
							2'h1: scl_q <= 1'b1;
							2'h2: begin
								o_q  <= 1'b0;
								oe_q <= 1'b1;
							end
							default: begin
								st_q  <= H_BIT;
								bit_q <= 4'h0;
								sh_q  <= d_cur[7:0];
							end
						endcase
					end
					H_BIT: begin
						case (ph_q)
							2'h0: begin
								scl_q <= 1'b0;
								o_q   <= spi_q & sh_q[7];
								if (bit_q == 4'h8)
									oe_q <= d_cur[10] & ~d_cur[11];
								else if (d_cur[10])
									oe_q <= 1'b0;
								else
									oe_q <= spi_q | ~sh_q[7];
							end
							2'h2: scl_q <= 1'b1;
							2'h3: begin
								if (nack_now)
									nack_q <= 1'b1;
								if (bit_q != 4'h8) begin
									sh_q <= {sh_q[6:0], 1'b0};
									if (d_cur[10])
										rd_q <= {rd_q[38:0], sda_s};
								end
								if (bit_q == (spi_q ? 4'h7 : 4'h8)) begin
									if (d_cur[11] || nack_now) begin
										st_q <= H_STO;
									end else begin
										bi_q  <= bi_q + 4'h1;
										bit_q <= 4'h0;
										sh_q  <= d_nxt[7:0];
										if (d_nxt[9])
											st_q <= H_STA;
									end
								end else begin
									bit_q <= bit_q + 4'h1;
								end
							end
							default: ;
						endcase
					end
					H_STO: begin
						case (ph_q)
							2'h0: begin
								scl_q <= 1'b0;
								o_q   <= 1'b0;
								oe_q  <= ~spi_q;
							end
							2'h1: scl_q <= ~spi_q;
							2'h2: oe_q <= 1'b0;
							default: begin
								sel_q <= 1'b1;
								st_q  <= H_IDLE;
								if (meas_q && !nack_q)
									guard_q <= 24'(GUARD_CYC);
								if (!meas_q && !nack_q) begin
									if (ponly_q) begin
										pres_q <= rd_q[23:0];
									end else begin
										pres_q <= rd_q[39:16];
										temp_q <= rd_q[15:0];
									end
								end
							end
						endcase
					end
					default: st_q <= H_IDLE;
				endcase
			end
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign lnk.scl      = scl_q;
	assign lnk.sel      = sel_q;
	assign lnk.h_sda_o  = o_q;
	assign lnk.h_sda_oe = oe_q;

endmodule : bsr_host
`default_nettype wire

// ==== tb/bsr_link_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================
// Link checker beside the host-device interface.
module bsr_link_chk (
	input wire logic pclk,     // System clock.
	input wire logic presetn,  // Reset, low active.
	input wire logic scl,      // Serial clock.
	input wire logic sel,      // Mode select.
	input wire logic h_sda_o,  // Host data.
	input wire logic h_sda_oe, // Host enable.
	input wire logic d_sda_o,  // Device data.
	input wire logic d_sda_oe, // Device enable.
	input wire logic sda       // Resolved line.
);
	// One domain, so clock and reset are named once.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_idle_after_rst: assert property ($rose(presetn) |->
		scl && sel && !h_sda_oe && !d_sda_oe) else $error("link busy after reset");
	a_sel_release: assert property ($rose(sel) |-> ##6 !d_sda_oe)
		else $error("device held line after select rose");
	a_dev_hold_high: assert property (scl && $past(scl) |->
		$stable(d_sda_oe) && (!d_sda_oe || $stable(d_sda_o))) else $error("device moved on high");
	a_host_hold_spi: assert property (!sel && !$past(sel) && scl && $past(scl) |->
		$stable(h_sda_o) && $stable(h_sda_oe)) else $error("host moved on high clock");
	a_start_by_host: assert property (sel && scl && $past(scl) && $fell(sda) |-> h_sda_oe)
		else $error("start not made by host");
	a_spi_cmd_quiet: assert property ($fell(sel) |-> !d_sda_oe [*8])
		else $error("device drove during command");
	// Each half of a bit lasts two quarters, well over eight cycles.
	a_scl_high_len: assert property ($rose(scl) |-> scl [*8]) else $error("clock high too short");
	a_scl_low_len: assert property ($fell(scl) |-> !scl [*8]) else $error("clock low too short");
	c_spi_frame: cover property ($fell(sel));
	c_i2c_answer: cover property (sel && $rose(d_sda_oe));
	c_spi_answer: cover property (!sel && $rose(d_sda_oe));
endmodule : bsr_link_chk
`default_nettype wire

// ==== tb/test_barometer_serial_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================
// Bench: host and device joined, driven over APB.
module test_barometer_serial_readout;
	import bsr_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        sensor_pwr, asleep, spi_mode, seen_spi;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] press_raw;
	logic [15:0] temp_raw;
	logic [23:0] pv [2] = '{24'h8F1E2D, 24'h3C4B5A};
	logic [15:0] tv [2] = '{16'hF3A0, 16'h1B2C};
	int          fail_count, checks, pwr_cyc;
	bsr_link_if lnk ();
	bsr_host #(.QTR_CYC(10), .GUARD_CYC(60)) i_bsr_host (.pclk(pclk), .presetn(presetn),
		.clk_en(1'b1), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.host));
	bsr_device #(.PHASE_CYC(20)) i_bsr_device (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.lnk(lnk.dev), .press_raw(press_raw), .temp_raw(temp_raw), .sensor_pwr(sensor_pwr),
		.asleep(asleep), .spi_mode(spi_mode));
	bsr_link_chk i_bsr_link_chk (.pclk(pclk), .presetn(presetn), .scl(lnk.scl), .sel(lnk.sel),
		.h_sda_o(lnk.h_sda_o), .h_sda_oe(lnk.h_sda_oe), .d_sda_o(lnk.d_sda_o),
		.d_sda_oe(lnk.d_sda_oe), .sda(lnk.sda));
	// Free-running system clock.
	always #2.5 pclk = ~pclk;
	// Count powered cycles and note any SPI mode seen.
	always @(posedge pclk) begin
		if (sensor_pwr === 1'b1) pwr_cyc <= pwr_cyc + 1;
		if (spi_mode === 1'b1) seen_spi <= 1'b1;
	end
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// One APB transfer; it waits for pready as long as it takes, only the watchdog ends a hang.
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Launch a sequence and poll status, at most 3000 times, until busy, error and guard are all clear.
	task run(input logic [31:0] ctrl);
		int n;
		apb(HREG_CTRL, 1'b1, ctrl);
		n = 0;
		do begin
			apb(HREG_STAT, 1'b0, 32'h0);
			n++;
		end while (rd[2:0] !== 3'h0 && n < 3000);
		cmp({29'h0, rd[2:0]}, 32'h0);
	endtask : run
	task wrap_up;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// Watchdog well beyond the expected run length.
	initial begin
		#450000;
		fail_count++;
		wrap_up;
	end
	initial begin
		pclk = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, press_raw, temp_raw} = '0;
		{fail_count, checks, pwr_cyc, seen_spi} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(HREG_PRES, 1'b0, 32'h0);
		cmp(rd, 32'h0);
		apb(12'h010, 1'b0, 32'h0);
		cmp({31'h0, e}, 32'h1);
		// Loop over I2C, then SPI: measure, alter raw inputs, fetch twice.
		for (int m = 0; m < 2; m++) begin
			press_raw <= pv[m];
			temp_raw <= tv[m];
			pwr_cyc = 0;
			run({29'h0, m[0], 2'h1});
			cmp(pwr_cyc, 32'd40);
			cmp({31'h0, asleep}, 32'h1);
			cmp({31'h0, seen_spi}, {31'h0, m[0]});
			press_raw <= ~pv[m];
			temp_raw <= ~tv[m];
			run({29'h0, m[0], 2'h2});
			apb(HREG_PRES, 1'b0, 32'h0);
			cmp(rd, {8'h0, pv[m]});
			apb(HREG_TEMP, 1'b0, 32'h0);
			cmp({16'h0, rd[15:0]}, {16'h0, tv[m]});
			run({28'h0, 1'b1, m[0], 2'h2});
			apb(HREG_PRES, 1'b0, 32'h0);
			cmp(rd, {8'h0, pv[m]});
		end
		wrap_up;
	end
endmodule : test_barometer_serial_readout
`default_nettype wire
